// ---- acvc_pkg.sv ----
// shared constants, types and decoding for the axis current value change block
// Notes on behaviour
// - a current value change overwrites the stopped axis current feed position with the user value.
// - a current value change never touches the machine feed position.
// - starting a current value change entry loads its target address field at the start.
// - an entry set to continuous path gives error 515 and does not start.
// - a continuous path entry just before the change entry gives error 515 and a deceleration stop.
// - in degree units an entry target outside 0 to 359.99999 degrees gives error 514, no start.
// - an entry target beyond the stroke limits gives 507 (upper) or 508 (lower), no start.
// - an entry change in infinite length mode gives error 524, no start.
// - start number 9003 plus start copies the new position value into the current feed position.
// - a start number change in degree units outside the range gives error 514.
// - a start number change beyond the stroke limits gives no error; the next move start gives 507/508.
// - no change is made while a stop command or the auxiliary code output is active.
// - a start number change in infinite length mode gives error 543 at the start.
// - changeover control waits the dwell time after a position stop, not after a speed stop.
package acvc_pkg;
	// ************************************************************
	// register map, byte addresses
	// ************************************************************
	localparam logic [7:0] ACVC_OFF_CTRL = 8'h00;
	localparam logic [7:0] ACVC_OFF_START = 8'h04;
	localparam logic [7:0] ACVC_OFF_NEWVAL = 8'h08;
	localparam logic [7:0] ACVC_OFF_UPPER = 8'h0c;
	localparam logic [7:0] ACVC_OFF_LOWER = 8'h10;
	localparam logic [7:0] ACVC_OFF_ENTRY = 8'h14;
	localparam logic [7:0] ACVC_OFF_TARGET = 8'h18;
	localparam logic [7:0] ACVC_OFF_DWELL = 8'h1c;
	localparam logic [7:0] ACVC_OFF_AUX = 8'h20;
	localparam logic [7:0] ACVC_OFF_CUR = 8'h24;
	localparam logic [7:0] ACVC_OFF_MACH = 8'h28;
	localparam logic [7:0] ACVC_OFF_STATUS = 8'h2c;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int ACVC_CTRL_START = 0;
	localparam int ACVC_CTRL_STOP = 1;
	localparam int ACVC_CTRL_AUX_ON = 2;
	localparam int ACVC_CTRL_DEG = 3;
	localparam int ACVC_CTRL_INF = 4;
	localparam int ACVC_CTRL_CHG = 5;
	localparam int ACVC_CTRL_ERR_CLR = 8;
	localparam int ACVC_ENT_OP_LSB = 0;
	localparam int ACVC_ENT_METH_LSB = 4;
	localparam int ACVC_ENT_PREV_LSB = 8;
	localparam int ACVC_ST_BUSY = 0;
	localparam int ACVC_ST_DONE = 1;
	localparam int ACVC_ST_DECEL = 2;
	localparam int ACVC_ST_ERR_LSB = 16;
	// ************************************************************
	// encodings and values
	// ************************************************************
	localparam logic [1:0] ACVC_OP_CONT_PATH = 2'h3;
	localparam logic [3:0] ACVC_METH_ABS = 4'h1;
	localparam logic [3:0] ACVC_METH_SPEED_POS = 4'h2;
	localparam logic [3:0] ACVC_METH_CHANGE = 4'h3;
	localparam logic [15:0] ACVC_START_NUM_CHANGE = 16'h232b;
	localparam logic [15:0] ACVC_ERR_NONE = 16'h0000;
	localparam logic [15:0] ACVC_ERR_STROKE_UP = 16'h01fb;
	localparam logic [15:0] ACVC_ERR_STROKE_LO = 16'h01fc;
	localparam logic [15:0] ACVC_ERR_RANGE = 16'h0202;
	localparam logic [15:0] ACVC_ERR_CHANGE = 16'h0203;
	localparam logic [15:0] ACVC_ERR_METHOD = 16'h020c;
	localparam logic [15:0] ACVC_ERR_START_NUM = 16'h021f;
	// degree positions in 1e-5 degree, so 359.99999 degrees is this count
	localparam logic signed [31:0] ACVC_DEG_MAX = 32'sh022550ff;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int ACVC_CLK_PERIOD_PS = 5000;
	localparam int ACVC_DWELL_UNIT_MS = 1;
	localparam int ACVC_MS_CYCLES = ACVC_DWELL_UNIT_MS * 1000000000 / ACVC_CLK_PERIOD_PS;
	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {ACVC_IDLE, ACVC_SPEED, ACVC_POS, ACVC_DWELL} acvc_mode_t;
	typedef struct packed {
		logic over_upper;
		logic under_lower;
		logic out_degree;
	} acvc_range_t;
	// continuous path pattern decode, used for both the entry and its predecessor
	function automatic logic acvc_is_cont_path(input logic [1:0] pat);
		return pat == ACVC_OP_CONT_PATH;
	endfunction
endpackage

// ---- acvc_range_check.sv ----
// range checker for stroke limits and the degree window
`timescale 1ns/1ps
`default_nettype none
module acvc_range_check import acvc_pkg::*; (
	input wire logic signed [31:0] value,
	input wire logic signed [31:0] upper,
	input wire logic signed [31:0] lower,
	output acvc_range_t flags
);
	// ************************************************************
	// compare against the limits
	// ************************************************************
	assign flags.over_upper = value > upper;
	assign flags.under_lower = value < lower;
	assign flags.out_degree = (value < 32'sh00000000) || (value > ACVC_DEG_MAX);
endmodule
`default_nettype wire

// ---- acvc_dwell_timer.sv ----
// millisecond dwell timer
`timescale 1ns/1ps
`default_nettype none
module acvc_dwell_timer import acvc_pkg::*; #(
	parameter int unsigned MS_CYCLES = ACVC_MS_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic [15:0] dwell_ms,
	output logic done
);
	typedef struct packed {
		logic run;
		logic [15:0] ms_left;
		logic [31:0] pre;
		logic done;
	} acvc_dwell_state_t;
	acvc_dwell_state_t st_ff;
	acvc_dwell_state_t nxt_st;
	// ************************************************************
	// prescaler to milliseconds, then count milliseconds down
	// ************************************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (go) begin
			nxt_st.pre = 32'h00000000;
			nxt_st.ms_left = dwell_ms;
			nxt_st.run = dwell_ms != 16'h0000;
			nxt_st.done = dwell_ms == 16'h0000; // zero dwell ends at once
		end else if (st_ff.run) begin
			if (st_ff.pre == 32'(MS_CYCLES - 1)) begin
				nxt_st.pre = 32'h00000000;
				if (st_ff.ms_left == 16'h0001) begin
					nxt_st.run = 1'b0;
					nxt_st.done = 1'b1;
				end else begin
					nxt_st.ms_left = st_ff.ms_left - 16'h0001;
				end
			end else begin
				nxt_st.pre = st_ff.pre + 32'h00000001;
			end
		end
	end
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign done = st_ff.done;
endmodule
`default_nettype wire

// ---- acvc_axis.sv ----
// axis current value change and positioning core with apb registers
`timescale 1ns/1ps
`default_nettype none
module acvc_axis import acvc_pkg::*; #(
	parameter int unsigned MS_CYCLES = ACVC_MS_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic step_out,
	output logic step_dir,
	output logic busy,
	output logic pos_complete
);
	// complete record of the axis, kept in one register bank
	typedef struct packed {
		acvc_mode_t mode;
		logic stop_cmd;
		logic aux_on;
		logic unit_deg;
		logic inf_mode;
		logic chg_sig;
		logic [15:0] start_num;
		logic signed [31:0] new_val;
		logic signed [31:0] upper;
		logic signed [31:0] lower;
		logic signed [31:0] target;
		logic signed [31:0] cur;
		logic signed [31:0] mach;
		logic signed [31:0] remain;
		logic [1:0] op_pat;
		logic [1:0] prev_pat;
		logic [3:0] method;
		logic [15:0] dwell_ms;
		logic [15:0] aux_code;
		logic [15:0] err;
		logic complete;
		logic decel;
		logic step;
		logic dir;
		logic dwell_go;
		logic [31:0] rdata;
		logic slverr;
	} acvc_state_t;
	acvc_state_t st_ff;
	acvc_state_t nxt_st;
	// bus strobes, sequencer step controls and helper results
	logic wr;
	logic start;
	logic err_clr;
	logic do_step;
	logic step_fwd;
	logic dwell_done;
	logic signed [31:0] chk_val;
	acvc_range_t rng;
	// ************************************************************
	// shared decodes
	// ************************************************************
	// a live stop command or auxiliary code output holds off either kind of change
	function automatic logic change_held(input logic stop, input logic aux);
		return stop || aux;
	endfunction
	// in degree units a position is only legal inside one turn
	function automatic logic degree_bad(input logic unit_deg, input acvc_range_t f);
		return unit_deg && f.out_degree;
	endfunction
	// ************************************************************
	// range check on the value the next start will use
	// ************************************************************
	always_comb begin
		if (st_ff.start_num == ACVC_START_NUM_CHANGE) begin
			chk_val = st_ff.new_val;
		end else if (st_ff.method == ACVC_METH_CHANGE) begin
			chk_val = st_ff.target;
		end else begin
			chk_val = st_ff.cur;
		end
	end
	// one checker serves the start number value, the entry target and the held position
	acvc_range_check u_rng (
		.value(chk_val),
		.upper(st_ff.upper),
		.lower(st_ff.lower),
		.flags(rng)
	);
	// dwell timer takes a one-cycle go and answers with a one-cycle done
	acvc_dwell_timer #(.MS_CYCLES(MS_CYCLES)) u_dwell (
		.pclk(pclk),
		.presetn(presetn),
		.go(st_ff.dwell_go),
		.dwell_ms(st_ff.dwell_ms),
		.done(dwell_done)
	);
	// ************************************************************
	// apb decode
	// ************************************************************
	// zero wait states, so every access phase is also the edge that commits a write
	assign wr = psel && penable && pwrite;
	assign start = wr && (paddr == ACVC_OFF_CTRL) && pwdata[ACVC_CTRL_START];
	assign err_clr = wr && (paddr == ACVC_OFF_CTRL) && pwdata[ACVC_CTRL_ERR_CLR];
	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.step = 1'b0;
		nxt_st.dwell_go = 1'b0;
		do_step = 1'b0;
		step_fwd = 1'b1;
		// register writes in the access phase
		if (wr) begin
			case (paddr)
				ACVC_OFF_CTRL: begin
					nxt_st.stop_cmd = pwdata[ACVC_CTRL_STOP];
					nxt_st.aux_on = pwdata[ACVC_CTRL_AUX_ON];
					nxt_st.unit_deg = pwdata[ACVC_CTRL_DEG];
					nxt_st.inf_mode = pwdata[ACVC_CTRL_INF];
					nxt_st.chg_sig = pwdata[ACVC_CTRL_CHG];
				end
				ACVC_OFF_START: nxt_st.start_num = pwdata[15:0];
				ACVC_OFF_NEWVAL: nxt_st.new_val = pwdata;
				ACVC_OFF_UPPER: nxt_st.upper = pwdata;
				ACVC_OFF_LOWER: nxt_st.lower = pwdata;
				// one entry word carries pattern, method and the predecessor pattern
				ACVC_OFF_ENTRY: begin
					nxt_st.op_pat = pwdata[ACVC_ENT_OP_LSB +: 2];
					nxt_st.method = pwdata[ACVC_ENT_METH_LSB +: 4];
					nxt_st.prev_pat = pwdata[ACVC_ENT_PREV_LSB +: 2];
				end
				ACVC_OFF_TARGET: nxt_st.target = pwdata;
				ACVC_OFF_DWELL: nxt_st.dwell_ms = pwdata[15:0];
				ACVC_OFF_AUX: nxt_st.aux_code = pwdata[15:0];
				default: ;
			endcase
		end
		// clear first so that an error raised in the same cycle wins
		if (err_clr) begin
			nxt_st.err = ACVC_ERR_NONE;
		end
		// read data captured in the setup phase, unmapped reads answer slverr
		if (psel && !penable) begin
			nxt_st.slverr = 1'b0;
			case (paddr)
				ACVC_OFF_CTRL: nxt_st.rdata = {26'h0000000, st_ff.chg_sig, st_ff.inf_mode,
					st_ff.unit_deg, st_ff.aux_on, st_ff.stop_cmd, 1'b0};
				ACVC_OFF_START: nxt_st.rdata = {16'h0000, st_ff.start_num};
				ACVC_OFF_NEWVAL: nxt_st.rdata = st_ff.new_val;
				ACVC_OFF_UPPER: nxt_st.rdata = st_ff.upper;
				ACVC_OFF_LOWER: nxt_st.rdata = st_ff.lower;
				ACVC_OFF_ENTRY: nxt_st.rdata = {22'h000000, st_ff.prev_pat, st_ff.method,
					2'h0, st_ff.op_pat};
				ACVC_OFF_TARGET: nxt_st.rdata = st_ff.target;
				ACVC_OFF_DWELL: nxt_st.rdata = {16'h0000, st_ff.dwell_ms};
				ACVC_OFF_AUX: nxt_st.rdata = {16'h0000, st_ff.aux_code};
				ACVC_OFF_CUR: nxt_st.rdata = st_ff.cur;
				ACVC_OFF_MACH: nxt_st.rdata = st_ff.mach;
				ACVC_OFF_STATUS: nxt_st.rdata = {st_ff.err, 13'h0000, st_ff.decel,
					st_ff.complete, st_ff.mode != ACVC_IDLE};
				default: begin
					nxt_st.rdata = 32'h00000000;
					nxt_st.slverr = 1'b1;
				end
			endcase
		end
		// axis sequencing
		case (st_ff.mode)
			ACVC_IDLE: begin
				// only an idle axis takes a start; a start while moving is dropped
				if (start) begin
					nxt_st.complete = 1'b0;
					nxt_st.decel = 1'b0;
					if (st_ff.start_num == ACVC_START_NUM_CHANGE) begin
						// start number change path, value written beforehand
						if (st_ff.inf_mode) begin
							nxt_st.err = ACVC_ERR_START_NUM;
						end else if (change_held(st_ff.stop_cmd, st_ff.aux_on)) begin
							nxt_st.complete = 1'b0;
						end else if (degree_bad(st_ff.unit_deg, rng)) begin
							nxt_st.err = ACVC_ERR_RANGE;
						end else begin
							// no stroke check here, no pulses, machine value kept
							nxt_st.cur = st_ff.new_val;
							nxt_st.complete = 1'b1;
						end
					end else if (st_ff.method == ACVC_METH_CHANGE) begin
						if (change_held(st_ff.stop_cmd, st_ff.aux_on)) begin
							nxt_st.complete = 1'b0;
						end else if (acvc_is_cont_path(st_ff.op_pat)) begin
							nxt_st.err = ACVC_ERR_CHANGE;
						end else if (acvc_is_cont_path(st_ff.prev_pat)) begin
							nxt_st.err = ACVC_ERR_CHANGE;
							nxt_st.decel = 1'b1;
						end else if (st_ff.inf_mode) begin
							nxt_st.err = ACVC_ERR_METHOD;
						end else if (degree_bad(st_ff.unit_deg, rng)) begin
							nxt_st.err = ACVC_ERR_RANGE;
						end else if (rng.over_upper) begin
							nxt_st.err = ACVC_ERR_STROKE_UP;
						end else if (rng.under_lower) begin
							nxt_st.err = ACVC_ERR_STROKE_LO;
						end else begin
							// only the stored value moves, no step pulses
							nxt_st.cur = st_ff.target;
							nxt_st.complete = 1'b1;
						end
					// a move checks the position it starts from
					end else if (st_ff.method == ACVC_METH_ABS ||
						st_ff.method == ACVC_METH_SPEED_POS) begin
						// a value left beyond the stroke limits stops the next move
						if (rng.over_upper) begin
							nxt_st.err = ACVC_ERR_STROKE_UP;
						end else if (rng.under_lower) begin
							nxt_st.err = ACVC_ERR_STROKE_LO;
						end else if (st_ff.method == ACVC_METH_ABS) begin
							nxt_st.remain = st_ff.target - st_ff.cur;
							nxt_st.mode = ACVC_POS;
						end else begin
							nxt_st.mode = ACVC_SPEED;
						end
					end
				end
			end
			// speed part: one forward step per cycle until stopped or switched over
			ACVC_SPEED: begin
				if (st_ff.stop_cmd) begin
					// stop during speed control completes without dwell
					nxt_st.mode = ACVC_IDLE;
					nxt_st.complete = 1'b1;
				end else if (st_ff.chg_sig) begin
					nxt_st.remain = st_ff.target;
					nxt_st.mode = ACVC_POS;
				end else begin
					do_step = 1'b1;
				end
			end
			// position part: step until no distance remains
			ACVC_POS: begin
				if (st_ff.stop_cmd || st_ff.remain == 32'sh00000000) begin
					// position stop: wait the dwell before completing
					nxt_st.mode = ACVC_DWELL;
					nxt_st.dwell_go = 1'b1;
				end else begin
					do_step = 1'b1;
					step_fwd = st_ff.remain > 32'sh00000000;
				end
			end
			// busy stays high until the timer reports the dwell over
			ACVC_DWELL: begin
				if (dwell_done) begin
					nxt_st.mode = ACVC_IDLE;
					nxt_st.complete = 1'b1;
				end
			end
			// an unused mode code falls back to idle
			default: nxt_st.mode = ACVC_IDLE;
		endcase
		// one motion pulse moves both feed positions together
		// so the gap that a current value change left between them is kept
		if (do_step) begin
			nxt_st.step = 1'b1;
			nxt_st.dir = step_fwd;
			if (step_fwd) begin
				nxt_st.cur = st_ff.cur + 32'sh00000001;
				nxt_st.mach = st_ff.mach + 32'sh00000001;
				nxt_st.remain = st_ff.remain - 32'sh00000001;
			end else begin
				nxt_st.cur = st_ff.cur - 32'sh00000001;
				nxt_st.mach = st_ff.mach - 32'sh00000001;
				nxt_st.remain = st_ff.remain + 32'sh00000001;
			end
		end
	end
	// ************************************************************
	// state register
	// ************************************************************
	// one flop bank for the whole axis state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	// ************************************************************
	// outputs
	// ************************************************************
	assign prdata = st_ff.rdata;
	assign pslverr = st_ff.slverr;
	// the slave never stretches a transfer
	assign pready = 1'b1; // zero wait states
	assign step_out = st_ff.step;
	assign step_dir = st_ff.dir;
	// busy is decoded from the registered mode, so bus activity cannot glitch it
	assign busy = st_ff.mode != ACVC_IDLE;
	assign pos_complete = st_ff.complete;
endmodule
`default_nettype wire

// ---- acvc_checker.sv ----
// assertion checker for the axis current value change block
`timescale 1ns/1ps
`default_nettype none
module acvc_checker import acvc_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic step_out,
	input wire logic step_dir,
	input wire logic busy,
	input wire logic pos_complete
);
	logic [4:1] mode_ff;
	logic [15:0] snum_ff;
	logic [31:0] mach_ff;
	logic seen_ff;
	logic moved_ff;
	logic wr;
	logic rd;
	logic go;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ************************************************************
	// helper state
	// ************************************************************
	// bus decode; go is a start write accepted while idle
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign go = wr && paddr == ACVC_OFF_CTRL && pwdata[0] && !busy;
	// mirror of mode bits, start number and last machine position read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= 4'h0;
			snum_ff <= 16'h0;
			mach_ff <= 32'h0;
			seen_ff <= 1'b0;
			moved_ff <= 1'b0;
		end else begin
			if (wr && paddr == ACVC_OFF_CTRL) begin
				mode_ff <= pwdata[4:1];
			end
			if (wr && paddr == ACVC_OFF_START) begin
				snum_ff <= pwdata[15:0];
			end
			if (rd && paddr == ACVC_OFF_MACH) begin
				mach_ff <= prdata;
				seen_ff <= 1'b1;
				moved_ff <= 1'b0;
			end
			if (step_out) begin
				moved_ff <= 1'b1;
			end
		end
	end
	// ************************************************************
	// properties
	// ************************************************************
	bus_ready_a: assert property (psel |-> pready)
		else $error("pready low during a transfer");
	mapped_ok_a: assert property (psel && penable && paddr <= ACVC_OFF_STATUS
		&& paddr[1:0] == 2'h0 |-> !pslverr) else $error("slverr on a mapped address");
	unmapped_err_a: assert property (psel && penable && paddr > ACVC_OFF_STATUS |-> pslverr)
		else $error("no slverr on an unmapped address");
	rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved outside a setup edge");
	no_pulse_a: assert property (step_out |-> busy || $past(busy))
		else $error("step pulse while idle");
	mach_hold_a: assert property (rd && paddr == ACVC_OFF_MACH && seen_ff && !moved_ff
		|-> prdata == mach_ff) else $error("machine position changed without steps");
	stop_block_a: assert property (go && (mode_ff[1] || mode_ff[2])
		&& (pwdata[1] || pwdata[2]) |=> !pos_complete) else $error("change done while blocked");
	num_change_a: assert property (go && snum_ff == ACVC_START_NUM_CHANGE && mode_ff == 4'h0
		&& pwdata[4:1] == 4'h0 |=> pos_complete && !busy) else $error("start number change not done");
endmodule
bind acvc_axis acvc_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .step_out(step_out), .step_dir(step_dir),
	.busy(busy), .pos_complete(pos_complete));
`default_nettype wire

// ---- acvc_axis_test.sv ----
// self-checking testbench for the axis current value change block
`timescale 1ns/1ps
`default_nettype none
module acvc_axis_test import acvc_pkg::*; ;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic step_out;
	logic step_dir;
	logic busy;
	logic pos_complete;
	int n_errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int steps = 0;
	int s0 = 0;
	logic [64:0] expq[$];
	logic [64:0] e;
	logic signed [31:0] cur = 32'h0;
	logic signed [31:0] r;
	acvc_axis #(.MS_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .step_out(step_out), .step_dir(step_dir),
		.busy(busy), .pos_complete(pos_complete));
	// ************************************************************
	// clock, monitor and verdict
	// ************************************************************
	initial begin
		forever #2.5 pclk = ~pclk;
	end
	task automatic print_verdict();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// takes the oldest note at each completed read; also cuts a hang short
	always @(posedge pclk) begin
		cyc++;
		if (step_out === 1'b1) begin
			steps = step_dir ? steps + 1 : steps - 1;
		end
		if (cyc > 20000) begin
			n_errors++;
			print_verdict();
		end else if (psel && penable && !pwrite && pready === 1'b1 && expq.size() > 0) begin
			e = expq.pop_front();
			samples_checked++;
			if ({pslverr, prdata & e[63:32]} !== {e[64], e[31:0] & e[63:32]}) begin
				n_errors++;
				$display("BAD t=%0t got %h exp %h", $time, {pslverr, prdata}, {e[64], e[31:0]});
			end
		end
	end
	// ************************************************************
	// bus and scenario tasks
	// ************************************************************
	// one apb transfer, held until pready is sampled high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
		input logic s);
		expq.push_back({s, m, v});
		bus(1'b0, a, 32'h0);
	endtask
	// error clear, then start with the given mode bits
	task automatic st(input logic [31:0] c);
		bus(1'b1, ACVC_OFF_CTRL, c | 32'h100);
		bus(1'b1, ACVC_OFF_CTRL, c | 32'h1);
	endtask
	task automatic run(input logic [31:0] c, input logic [15:0] er, input logic ok,
		input logic signed [31:0] nv, input logic dcl);
		st(c);
		if (ok) begin
			cur = nv;
		end
		rd(ACVC_OFF_STATUS, {er, 13'h0, dcl, ok, 1'b0}, {16'hffff, 13'h0, dcl, 2'h2}, 1'b0);
		rd(ACVC_OFF_CUR, cur, 32'hffffffff, 1'b0);
	endtask
	task automatic sn(input logic signed [31:0] v, input logic [31:0] c, input logic [15:0] er,
		input logic ok);
		bus(1'b1, ACVC_OFF_NEWVAL, v);
		bus(1'b1, ACVC_OFF_START, {16'h0, ACVC_START_NUM_CHANGE});
		run(c, er, ok, v, 1'b0);
	endtask
	task automatic ec(input logic [31:0] en, input logic signed [31:0] t, input logic [31:0] c,
		input logic [15:0] er);
		bus(1'b1, ACVC_OFF_START, 32'h0);
		bus(1'b1, ACVC_OFF_ENTRY, en);
		bus(1'b1, ACVC_OFF_TARGET, t);
		run(c, er, er == ACVC_ERR_NONE, t, en[9:8] == 2'h3);
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		r = $urandom(32'he19beffc);
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(ACVC_OFF_STATUS, 32'h0, 32'hffffffff, 1'b0);
		rd(ACVC_OFF_MACH, 32'h0, 32'hffffffff, 1'b0);
		rd(8'h30, 32'h0, 32'hffffffff, 1'b1);
		bus(1'b1, ACVC_OFF_UPPER, 32'h3e8);
		bus(1'b1, ACVC_OFF_LOWER, 32'hfffffc18);
		r = int'($urandom_range(2000)) - 1000;
		sn(r, 32'h0, ACVC_ERR_NONE, 1'b1);
		rd(ACVC_OFF_MACH, 32'h0, 32'hffffffff, 1'b0);
		sn(r + 5, 32'h2, ACVC_ERR_NONE, 1'b0);
		sn(r + 5, 32'h4, ACVC_ERR_NONE, 1'b0);
		sn(r + 5, 32'h10, ACVC_ERR_START_NUM, 1'b0);
		sn(ACVC_DEG_MAX + 1, 32'h8, ACVC_ERR_RANGE, 1'b0);
		sn(32'hffffffff, 32'h8, ACVC_ERR_RANGE, 1'b0);
		sn(ACVC_DEG_MAX, 32'h8, ACVC_ERR_NONE, 1'b1);
		ec(32'h10, 32'h0, 32'h0, ACVC_ERR_STROKE_UP);
		sn(32'hfffff830, 32'h0, ACVC_ERR_NONE, 1'b1);
		ec(32'h10, 32'h0, 32'h0, ACVC_ERR_STROKE_LO);
		r = int'($urandom_range(2000)) - 1000;
		ec(32'h30, r, 32'h0, ACVC_ERR_NONE);
		ec(32'h33, 32'h7, 32'h0, ACVC_ERR_CHANGE);
		ec(32'h330, 32'h7, 32'h0, ACVC_ERR_CHANGE);
		ec(32'h30, 32'h7, 32'h10, ACVC_ERR_METHOD);
		ec(32'h30, 32'hffffffff, 32'h8, ACVC_ERR_RANGE);
		ec(32'h30, 32'h3e9, 32'h0, ACVC_ERR_STROKE_UP);
		ec(32'h30, 32'hfffffc17, 32'h0, ACVC_ERR_STROKE_LO);
		ec(32'h30, 32'h3e8, 32'h0, ACVC_ERR_NONE);
		rd(ACVC_OFF_MACH, 32'h0, 32'hffffffff, 1'b0);
		// speed stop skips the dwell, position stop waits it out
		bus(1'b1, ACVC_OFF_UPPER, 32'h000f4240);
		bus(1'b1, ACVC_OFF_DWELL, 32'h64);
		bus(1'b1, ACVC_OFF_TARGET, 32'h10);
		bus(1'b1, ACVC_OFF_START, 32'h0);
		bus(1'b1, ACVC_OFF_ENTRY, 32'h20);
		st(32'h0);
		bus(1'b1, ACVC_OFF_CTRL, 32'h2);
		rd(ACVC_OFF_STATUS, 32'h2, 32'h3, 1'b0);
		s0 = steps;
		st(32'h20);
		// 16 steps, then 400 cycles of dwell: the first look falls inside the dwell
		repeat (300) @(posedge pclk);
		rd(ACVC_OFF_STATUS, 32'h1, 32'h3, 1'b0);
		repeat (200) @(posedge pclk);
		rd(ACVC_OFF_STATUS, 32'h2, 32'h3, 1'b0);
		rd(ACVC_OFF_MACH, s0 + 32'h10, 32'hffffffff, 1'b0);
		rd(ACVC_OFF_CUR, 32'h3e8 + s0 + 32'h10, 32'hffffffff, 1'b0);
		repeat (3) @(posedge pclk);
		print_verdict();
	end
endmodule
`default_nettype wire
